/* File: src/fsrl_host.sv */
// programming-equipment controller: command sequences, status polling, readout lock
// Overview of operation
// RULE1 - status is read with an ordinary read cycle, chip select and output enable low
// RULE2 - ready/busy is trusted only after the last write strobe of a sequence rises
// RULE3 - a finished program or erase returns the flash to array read by itself
// RULE4 - program polling: poll bit shows complement of written data until done
// RULE5 - erase polling: poll bit reads 0 while erasing and 1 when finished
// RULE6 - poll bit freezes on failure, so it is judged together with time-limit bit
// RULE7 - poll at the programmed address or inside an erased unprotected block
// RULE8 - poll bit may change during a read, so it is not trusted within one read
// RULE9 - time-limit bit is 0 in normal progress and 1 once the limit is passed
// RULE10 - programming a 1 over a 0 halts and later sets the time-limit bit
// RULE11 - after a failure the flash stays busy until a read/reset command is written
// RULE12 - erase window opens at the sixth write strobe; window bit then goes 0 to 1
// RULE13 - while window bit is 0, more block erase sequences are taken and restart it
// RULE14 - read window bit before and after each added block erase; 1 after means rejected
// RULE15 - ready/busy pin is 0 while busy and 1 when a new command may follow
// RULE16 - ready/busy stays 0 after failure; commands written while it is 0 are ignored
// RULE17 - with readout locked every read returns 0x0098
// RULE18 - lock: security pin high, 0x0098 at address 0x0000 in the fourth cycle
// RULE19 - commands are ignored during lock or unlock; hardware reset aborts them
// RULE20 - security pin stays constant for the whole lock or unlock algorithm
// RULE21 - unlock wipes the whole array then clears the lock bit
// RULE22 - a failed lock or unlock leaves the flash busy; lock stays set on wipe failure
// RULE23 - security pin is high only for the lock and unlock sequences
// RULE24 - command data halfwords carry 0x00 in the upper byte
`timescale 1ns/1ps
module fsrl_host
  import fsrl_pkg::*;
#(
  parameter logic [31:0] POLL_LIMIT = 32'd1000000,
  parameter logic [31:0] RDY_LIMIT  = 32'd1000000
) (
  input  wire logic              REF_CLK,     // 50 MHz system clock
  input  wire logic              RESET,       // synchronous reset, high
  input  wire logic              CLK_EN,      // freezes all state while low
  input  wire logic              CMD_VALID,   // user command request
  output logic                   CMD_READY,   // controller idle
  input  wire fsrl_cmd_t         CMD,         // user command
  output logic                   RSP_VALID,   // one-cycle completion pulse
  output logic      [DATA_W-1:0] RSP_DATA,    // last halfword read
  output fsrl_status_t           RSP_STATUS,  // outcome flags
  output logic                   FL_CE_N,     // flash chip enable, low
  output logic                   FL_OE_N,     // flash output enable, low
  output logic                   FL_WE_N,     // flash write strobe, low
  output logic                   FL_FSE,      // security enable pin
  output logic      [ADDR_W-1:0] FL_ADDR,     // flash address
  output logic      [DATA_W-1:0] FL_DQ_O,     // data driven to flash
  output logic                   FL_DQ_OE_N,  // low while driving data
  input  wire logic [DATA_W-1:0] FL_DQ_I,     // data from flash
  input  wire logic              FL_READY_BUSY_PIN   // ready/busy pin
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_WAIT_RDY = 8'h02, ST_WR_SETUP = 8'h04, ST_WR_PULSE = 8'h08,
    ST_WR_RECOV = 8'h10, ST_RD_SETUP = 8'h20, ST_RD_SAMPLE = 8'h40, ST_RESP = 8'h80
  } fsrl_state_t;

  typedef enum logic [5:0] {
    PH_READ = 6'h01, PH_PRE = 6'h02, PH_WRITE = 6'h04,
    PH_POST = 6'h08, PH_POLL = 6'h10, PH_RECOV = 6'h20
  } fsrl_phase_t;

  fsrl_state_t       state_ff, nxt_state;
  fsrl_phase_t       ph_ff, nxt_ph;
  fsrl_cmd_t         cmd_ff, nxt_cmd;
  fsrl_status_t      status_ff, nxt_status;
  logic [2:0]        idx_ff, nxt_idx;
  logic [7:0]        cnt_ff, nxt_cnt;
  logic [31:0]       polls_ff, nxt_polls;
  logic              dq5_seen_ff, nxt_dq5_seen;
  logic              fse_ff, nxt_fse;
  logic              rsp_valid_ff, nxt_rsp_valid;
  logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
  logic [DATA_W-1:0] dq_s;
  logic              rdy_s;
  logic              poll_exp;
  logic              fail_now;
  fsrl_op_t          seq_op;
  fsrl_word_t        wr_word;
  logic [ADDR_W-1:0] poll_addr;

  fsrl_sync #(.W(DATA_W + 1)) u_pin_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .en  (CLK_EN),
    .d   ({FL_READY_BUSY_PIN, FL_DQ_I}),
    .q   ({rdy_s, dq_s})
  );

  assign seq_op     = (nxt_ph == PH_RECOV) ? OP_RESET : nxt_cmd.op;
  assign wr_word    = seq_word(seq_op, nxt_idx, nxt_cmd.addr, nxt_cmd.data);
  // lock status reads back at the lock word address
  assign poll_addr  = (nxt_cmd.op == OP_LOCK) ? ADDR_W'(ADR_SECURE) : nxt_cmd.addr; // RULE7
  assign poll_exp   = (cmd_ff.op == OP_PROGRAM) ? cmd_ff.data[POLL_BIT] :          // RULE4
                      (cmd_ff.op == OP_LOCK) ? D_SECURE_ON[POLL_BIT] : POLL_ERASE_DONE; // RULE5
  assign CMD_READY  = (state_ff == ST_IDLE);
  assign RSP_VALID  = rsp_valid_ff;
  assign RSP_DATA   = rsp_data_ff;
  assign RSP_STATUS = status_ff;

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_ph        = ph_ff;
    nxt_cmd       = cmd_ff;
    nxt_status    = status_ff;
    nxt_idx       = idx_ff;
    nxt_cnt       = cnt_ff;
    nxt_polls     = polls_ff;
    nxt_dq5_seen  = dq5_seen_ff;
    nxt_fse       = fse_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = rsp_data_ff;
    fail_now      = 1'b0;
    case (state_ff)
      ST_IDLE:
        if (CMD_VALID)
        begin
          nxt_cmd      = CMD;
          nxt_status   = '0;
          nxt_idx      = STEP_FIRST;
          nxt_cnt      = '0;
          nxt_polls    = '0;
          nxt_dq5_seen = 1'b0;
          nxt_fse      = (CMD.op == OP_LOCK) || (CMD.op == OP_UNLOCK); // RULE23 RULE21
          nxt_state    = ST_WAIT_RDY;
          nxt_ph       = (CMD.op == OP_BLOCK_ERASE) ? PH_PRE : PH_WRITE;
          case (CMD.op)
            OP_READ:
            begin
              nxt_ph    = PH_READ;
              nxt_state = ST_RD_SETUP;
            end
            OP_ERASE_WAIT:
            begin
              nxt_ph    = PH_POLL;
              nxt_state = ST_RD_SETUP;
            end
            // read/reset must pass even though a failed flash holds busy low
            OP_RESET: nxt_state = ST_WR_SETUP; // RULE11
            default: nxt_state = ST_WAIT_RDY;
          endcase
        end
      ST_WAIT_RDY:
        if (rdy_s) // RULE16 RULE15 RULE19
        begin
          nxt_polls = '0;
          nxt_state = (ph_ff == PH_PRE) ? ST_RD_SETUP : ST_WR_SETUP;
        end
        else if (polls_ff == RDY_LIMIT)
        begin
          nxt_status.rdy_timeout = 1'b1;
          nxt_fse                = 1'b0;
          nxt_state              = ST_RESP;
        end
        else
          nxt_polls = polls_ff + 32'h1;
      ST_WR_SETUP:
        if (cnt_ff == WR_SETUP_CYC - 8'h01)
        begin
          nxt_cnt   = '0;
          nxt_state = ST_WR_PULSE;
        end
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_WR_PULSE:
        if (cnt_ff == WE_PULSE_CYC - 8'h01)
        begin
          nxt_cnt   = '0;
          nxt_state = ST_WR_RECOV;
        end
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_WR_RECOV:
        if (cnt_ff != WR_HOLD_CYC - 8'h01)
          nxt_cnt = cnt_ff + 8'h01;
        else
        begin
          nxt_cnt = '0;
          if (idx_ff != seq_len((ph_ff == PH_RECOV) ? OP_RESET : cmd_ff.op) - 3'h1)
          begin
            nxt_idx   = idx_ff + 3'h1;
            nxt_state = ST_WR_SETUP;
          end
          // status is only polled once the final strobe has risen
          else if (ph_ff == PH_RECOV || cmd_ff.op == OP_RESET) // RULE2
            nxt_state = ST_RESP;
          else
          begin
            nxt_ph    = (cmd_ff.op == OP_BLOCK_ERASE) ? PH_POST : PH_POLL; // RULE12
            nxt_state = ST_RD_SETUP;
          end
        end
      ST_RD_SETUP:
        if (cnt_ff == RD_WAIT_CYC - 8'h01) // RULE1
        begin
          nxt_cnt   = '0;
          nxt_state = ST_RD_SAMPLE;
        end
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_RD_SAMPLE:
      begin
        nxt_state = ST_RESP;
        nxt_fse   = 1'b0;
        case (ph_ff)
          PH_READ:
          begin
            nxt_rsp_data      = dq_s;
            nxt_status.locked = (dq_s == D_LOCKED_READ); // RULE17
          end
          PH_PRE:
          begin
            nxt_status.window_closed = dq_s[WINDOW_BIT]; // RULE14
            nxt_ph                   = PH_WRITE;
            nxt_state                = ST_WR_SETUP;
            nxt_fse                  = fse_ff;
          end
          PH_POST:
          begin
            nxt_rsp_data              = dq_s;
            nxt_status.maybe_rejected = dq_s[WINDOW_BIT]; // RULE13
          end
          PH_POLL:
            // device went back to array read, so data reads true
            if (dq_s[POLL_BIT] == poll_exp) // RULE3
              nxt_rsp_data = dq_s;
            // a limit seen on an earlier read needs one fresh poll bit
            else if (dq5_seen_ff || polls_ff == POLL_LIMIT) // RULE6 RULE8
            begin
              fail_now          = 1'b1;
              nxt_status.failed = 1'b1;
              nxt_rsp_data      = dq_s;
              nxt_ph            = PH_RECOV; // RULE11 RULE22
              nxt_idx           = STEP_FIRST;
              nxt_state         = ST_WR_SETUP;
            end
            else
            begin
              nxt_dq5_seen = dq_s[LIMIT_BIT]; // RULE9 RULE10
              nxt_polls    = polls_ff + 32'h1;
              nxt_fse      = fse_ff; // RULE20
              nxt_state    = ST_RD_SETUP;
            end
          default: nxt_state = ST_RESP;
        endcase
      end
      ST_RESP:
      begin
        nxt_rsp_valid = 1'b1;
        nxt_state     = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state_ff <= ST_IDLE;
      ph_ff    <= PH_WRITE;
      idx_ff   <= STEP_FIRST;
      cnt_ff   <= '0;
      polls_ff <= '0;
    end
    else if (CLK_EN)
    begin
      state_ff <= nxt_state;
      ph_ff    <= nxt_ph;
      idx_ff   <= nxt_idx;
      cnt_ff   <= nxt_cnt;
      polls_ff <= nxt_polls;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      cmd_ff       <= '0;
      status_ff    <= '0;
      dq5_seen_ff  <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= '0;
    end
    else if (CLK_EN)
    begin
      cmd_ff       <= nxt_cmd;
      status_ff    <= nxt_status;
      dq5_seen_ff  <= nxt_dq5_seen;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff  <= nxt_rsp_data;
    end
  end

  // pins are registered from the next state so strobes never glitch
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      FL_CE_N    <= 1'b1;
      FL_OE_N    <= 1'b1;
      FL_WE_N    <= 1'b1;
      FL_DQ_OE_N <= 1'b1;
      FL_ADDR    <= '0;
      FL_DQ_O    <= '0;
      fse_ff     <= 1'b0;
    end
    else if (CLK_EN)
    begin
      FL_CE_N    <= !(nxt_state inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_RECOV, ST_RD_SETUP});
      FL_OE_N    <= (nxt_state != ST_RD_SETUP);
      FL_WE_N    <= (nxt_state != ST_WR_PULSE);
      FL_DQ_OE_N <= !(nxt_state inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_RECOV});
      FL_ADDR    <= (nxt_state == ST_RD_SETUP) ? poll_addr : wr_word.addr;
      FL_DQ_O    <= wr_word.data; // RULE24 RULE18
      fse_ff     <= nxt_fse;
    end
  end
  assign FL_FSE = fse_ff;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  AST_FSE_ONLY_SECURE: assert property (FL_FSE |-> (cmd_ff.op == OP_LOCK || // RULE23
                                                     cmd_ff.op == OP_UNLOCK))
    else $error("security pin high outside lock or unlock");
  AST_FSE_STEADY: assert property ((ph_ff == PH_POLL && $past(ph_ff) == PH_POLL && // RULE20
                                    state_ff != ST_RESP) |-> $stable(FL_FSE))
    else $error("security pin moved during algorithm");
  AST_CMD_UPPER_ZERO: assert property ((!FL_WE_N && !(cmd_ff.op == OP_PROGRAM && // RULE24
      idx_ff == STEP_ARG && ph_ff != PH_RECOV)) |-> FL_DQ_O[15:8] == '0)
    else $error("command data upper byte not zero");
  AST_LOCK_WORD: assert property ((!FL_WE_N && cmd_ff.op == OP_LOCK && // RULE18
      idx_ff == STEP_ARG && ph_ff == PH_WRITE) |->
      (FL_ADDR == ADDR_W'(ADR_SECURE) && FL_DQ_O == D_SECURE_ON && FL_FSE))
    else $error("lock word wrong");
  AST_POLL_AT_TARGET: assert property ((!FL_OE_N && ph_ff == PH_POLL && // RULE7
                                        cmd_ff.op != OP_LOCK) |-> FL_ADDR == cmd_ff.addr)
    else $error("polling away from target address");
  AST_FAIL_AFTER_DQ5: assert property ((state_ff == ST_RD_SAMPLE && ph_ff == PH_POLL && // RULE6
      nxt_ph == PH_RECOV && polls_ff != POLL_LIMIT) |-> dq5_seen_ff)
    else $error("failure declared without time limit flag");
  AST_RESET_AFTER_FAIL: assert property (fail_now |=> ##[1:8] // RULE11
                                         (!FL_WE_N && FL_DQ_O == D_READ_RESET && !FL_FSE))
    else $error("no read/reset after failure");
  AST_READ_STROBES: assert property ($fell(FL_OE_N) |-> // RULE1
      (!FL_OE_N && !FL_CE_N && FL_WE_N)[*8] ##1 FL_OE_N)
    else $error("read cycle strobes wrong");

  COV_PROGRAM_OK: cover property (RSP_VALID && cmd_ff.op == OP_PROGRAM && !RSP_STATUS.failed);
  COV_FAILED: cover property (RSP_VALID && RSP_STATUS.failed);
  COV_REJECTED: cover property (RSP_VALID && RSP_STATUS.maybe_rejected);
  COV_LOCKED_READ: cover property (RSP_VALID && RSP_STATUS.locked);
endmodule : fsrl_host

/* File: src/fsrl_pkg.sv */
// constants, types and command tables for the flash programming controller
package fsrl_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int T_WR_SETUP_NS  = 40;
  localparam int T_WE_PULSE_NS  = 100;
  localparam int T_WR_HOLD_NS   = 40;
  localparam int T_RD_ACCESS_NS = 120;
  localparam int SYNC_DEPTH     = 2;

  // least times round up, never below one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  localparam logic [7:0] WR_SETUP_CYC = 8'(ceil_cyc(T_WR_SETUP_NS));
  localparam logic [7:0] WE_PULSE_CYC = 8'(ceil_cyc(T_WE_PULSE_NS));
  localparam logic [7:0] WR_HOLD_CYC  = 8'(ceil_cyc(T_WR_HOLD_NS));
  localparam logic [7:0] RD_WAIT_CYC  = 8'(ceil_cyc(T_RD_ACCESS_NS) + SYNC_DEPTH);

  localparam logic [15:0] ADR_UNLOCK1 = 16'h5555;
  localparam logic [15:0] ADR_UNLOCK2 = 16'haaaa;
  localparam logic [15:0] ADR_SECURE  = 16'h0000;

  localparam logic [15:0] D_UNLOCK1     = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2     = 16'h0055;
  localparam logic [15:0] D_READ_RESET  = 16'h00f0;
  localparam logic [15:0] D_PROGRAM     = 16'h00a0;
  localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] D_CHIP_ERASE  = 16'h0010;
  localparam logic [15:0] D_BLOCK_ERASE = 16'h0030;
  localparam logic [15:0] D_SECURE_ON   = 16'h0098;
  localparam logic [15:0] D_LOCKED_READ = 16'h0098;

  localparam int POLL_BIT   = 7;
  localparam int LIMIT_BIT  = 5;
  localparam int WINDOW_BIT = 3;
  localparam logic POLL_ERASE_DONE = 1'b1;

  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_U2    = 3'h1;
  localparam logic [2:0] STEP_CMD   = 3'h2;
  localparam logic [2:0] STEP_ARG   = 3'h3;
  localparam logic [2:0] STEP_U4    = 3'h4;
  localparam logic [2:0] LEN_RESET  = 3'h1;
  localparam logic [2:0] LEN_SHORT  = 3'h4;
  localparam logic [2:0] LEN_LONG   = 3'h6;

  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_RESET       = 3'h1,
    OP_PROGRAM     = 3'h2,
    OP_CHIP_ERASE  = 3'h3,
    OP_BLOCK_ERASE = 3'h4,
    OP_ERASE_WAIT  = 3'h5,
    OP_LOCK        = 3'h6,
    OP_UNLOCK      = 3'h7
  } fsrl_op_t;

  typedef struct packed {
    fsrl_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsrl_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsrl_word_t;

  typedef struct packed {
    logic failed;
    logic maybe_rejected;
    logic locked;
    logic window_closed;
    logic rdy_timeout;
  } fsrl_status_t;

  function automatic logic [2:0] seq_len(input fsrl_op_t op);
    case (op)
      OP_RESET:            return LEN_RESET;
      OP_PROGRAM, OP_LOCK: return LEN_SHORT;
      default:             return LEN_LONG;
    endcase
  endfunction : seq_len

  function automatic fsrl_word_t seq_word(input fsrl_op_t op, input logic [2:0] idx,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d);
    fsrl_word_t w;
    w.addr = ADDR_W'(ADR_UNLOCK1);
    w.data = D_UNLOCK1;
    case (idx)
      STEP_FIRST:
        if (op == OP_RESET)
        begin
          w.addr = ADDR_W'(ADR_SECURE);
          w.data = D_READ_RESET;
        end
      STEP_U2, STEP_U4:
      begin
        w.addr = ADDR_W'(ADR_UNLOCK2);
        w.data = D_UNLOCK2;
      end
      STEP_CMD:
        w.data = (op == OP_PROGRAM || op == OP_LOCK) ? D_PROGRAM : D_ERASE_SETUP;
      STEP_ARG:
        if (op == OP_PROGRAM)
        begin
          w.addr = a;
          w.data = d;
        end
        else if (op == OP_LOCK)
        begin
          w.addr = ADDR_W'(ADR_SECURE);
          w.data = D_SECURE_ON;
        end
      default:
        if (op == OP_BLOCK_ERASE)
        begin
          w.addr = a;
          w.data = D_BLOCK_ERASE;
        end
        else
          w.data = D_CHIP_ERASE;
    endcase
    return w;
  endfunction : seq_word

endpackage : fsrl_pkg

/* File: src/fsrl_sync.sv */
// two-stage synchroniser with clock enable for pin inputs
`timescale 1ns/1ps
module fsrl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst,    // synchronous reset, high
  input  wire logic         en,     // clock enable
  input  wire logic [W-1:0] d,      // asynchronous input
  output logic      [W-1:0] q       // synchronised output
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else if (en)
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : fsrl_sync

/* File: test/fsrl_flash_model.sv */
// behavioural programmer-mode flash with status flags and lock bit
`timescale 1ns/1ps
module fsrl_flash_model
  import fsrl_pkg::*;
#(
  parameter int BUSY_CYC = 30,
  parameter int WIN_CYC  = 120
) (
  input  wire logic              clk,     // time base
  input  wire logic              rst,     // hardware reset
  input  wire logic              ce_n,    // chip enable
  input  wire logic              oe_n,    // output enable
  input  wire logic              we_n,    // write strobe
  input  wire logic              security_enable_pin,     // security enable
  input  wire logic [ADDR_W-1:0] addr,    // address
  input  wire logic [DATA_W-1:0] din,     // write data
  input  wire logic              fail_nx, // next algorithm other than block erase fails
  input  wire logic              hold,    // stay busy
  output logic      [DATA_W-1:0] dout,    // read data
  output logic                   rdy      // ready/busy
);
  logic [15:0] mem[16];
  logic [15:0] pd, cmd, last, st, val;
  logic [3:0]  pa, blk;
  logic [2:0]  cnt;
  logic [1:0]  kind;  // 0 program, 1 lock, 2 erase, 3 unlock
  logic        we_q, stuck, flt, lock, busy;
  int          left, win;

  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hffff;
    {last, pd, kind, lock} = '0;
  end

  always @(posedge clk)
  begin
    we_q <= we_n;
    if (rst)
    begin
      {cnt, stuck, flt, blk} <= '0;
      left <= 0;
      win  <= 0;
    end
    else
    begin
      if (left > 0)
        left <= left - 1;
      if (win > 0)
        win <= win - 1;
      if (win == 1)
        left <= BUSY_CYC;
      // a failed algorithm never ends by itself
      if (left == 1 && stuck)
        flt <= 1'b1;
      if (left == 1 && !stuck)
      begin
        if (kind == 2'd0)
          mem[pa] <= pd;
        if (kind[0])
          lock <= !kind[1];
        for (int i = 0; i < 16; i++)
          if (kind[1] && blk[i/4])
            mem[i] <= 16'hffff;
        blk <= '0;
      end
      if (we_n && !we_q && !ce_n)
      begin
        cnt <= cnt + 3'h1;
        if (din == D_READ_RESET)
        begin
          cnt <= '0;
          if (flt)
            {stuck, flt} <= '0;
        end
        else if (busy)
          cnt <= '0;
        else if (cnt == 3'h2)
          cmd <= din;
        else if (cnt == 3'h3 && cmd == D_PROGRAM)
        begin
          kind  <= {1'b0, security_enable_pin && din == D_SECURE_ON && addr == '0};
          pa    <= addr[3:0];
          pd    <= din;
          stuck <= fail_nx || |(din & ~mem[addr[3:0]]);
          left  <= BUSY_CYC;
          cnt   <= '0;
        end
        else if (cnt == 3'h5)
        begin
          cnt <= '0;
          if (din == D_CHIP_ERASE)
          begin
            kind  <= {1'b1, security_enable_pin};
            blk   <= 4'hf;
            stuck <= fail_nx;
            left  <= BUSY_CYC;
          end
          if (din == D_BLOCK_ERASE && !security_enable_pin)
          begin
            kind <= 2'd2;
            blk  <= blk | (4'h1 << addr[3:2]);
            win  <= WIN_CYC;
          end
        end
      end
    end
  end

  always_comb
  begin
    busy = left > 0 || stuck || hold;
    st = '0;
    st[7] = kind[1] ? 1'b0 : ~pd[7];
    st[5] = flt;
    st[3] = kind[1] ? (win == 0) : flt;
    val = (busy || win > 0) ? st : (lock ? D_LOCKED_READ : mem[addr[3:0]]);
    rdy = !busy;
    // released bus shows the inverse so stale data never looks valid
    dout = (!ce_n && !oe_n) ? val : ~last;
  end

  always @(posedge clk)
    if (!ce_n && !oe_n)
      last <= val;
endmodule : fsrl_flash_model

/* File: test/testbench.sv */
// self-checking bench for the flash programming controller
`timescale 1ns/1ps
module testbench;
  import fsrl_pkg::*;
  logic              REF_CLK, RESET, CMD_VALID, CMD_READY, RSP_VALID, FL_CE_N, FL_OE_N;
  logic              FL_WE_N, FL_FSE, FL_DQ_OE_N, FL_READY_BUSY_PIN, fse_exp, fail_nx, hold;
  logic              CLK_EN;
  logic [DATA_W-1:0] RSP_DATA, FL_DQ_O, FL_DQ_I, fl_q;
  logic [ADDR_W-1:0] FL_ADDR;
  fsrl_cmd_t         CMD;
  fsrl_status_t      RSP_STATUS;
  int                err_count, check_count, wr_cnt;

  fsrl_host #(.POLL_LIMIT(32'd40), .RDY_LIMIT(32'd16)) u_fsrl_host (
    .REF_CLK(REF_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD(CMD), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .RSP_STATUS(RSP_STATUS), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
    .FL_FSE(FL_FSE), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_N(FL_DQ_OE_N),
    .FL_DQ_I(FL_DQ_I), .FL_READY_BUSY_PIN(FL_READY_BUSY_PIN));

  fsrl_flash_model u_fsrl_flash_model (
    .clk(REF_CLK), .rst(RESET), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
    .security_enable_pin(FL_FSE), .addr(FL_ADDR), .din(FL_DQ_O), .fail_nx(fail_nx), .hold(hold),
    .dout(fl_q), .rdy(FL_READY_BUSY_PIN));

  assign FL_DQ_I = FL_DQ_OE_N ? fl_q : FL_DQ_O;

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
      bad(m);
  endtask : ck

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  always @(negedge FL_WE_N)
  begin
    wr_cnt++;
    check_count++;
    if (FL_FSE !== (fse_exp && FL_DQ_O != D_READ_RESET) || FL_DQ_O[15:8] !== 8'h00 ||
        FL_DQ_OE_N !== 1'b0)
      bad("write strobe with wrong security pin or data");
  end

  // one command, held until taken, then a bounded wait for its response
  task automatic run(input fsrl_op_t op, input logic [17:0] a, input logic [15:0] d,
                     input logic fx);
    int n;
    n = 0;
    @(negedge REF_CLK);
    fse_exp = fx;
    wr_cnt = 0;
    CMD_VALID = 1'b1;
    CMD = '{op, a, d};
    while (CMD_READY !== 1'b1)
      @(negedge REF_CLK);
    @(negedge REF_CLK);
    CMD_VALID = 1'b0;
    while (RSP_VALID !== 1'b1 && n < 4000)
    begin
      @(negedge REF_CLK);
      n++;
    end
    ck(n < 4000, "no response");
  endtask : run

  task automatic t_prog;
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_DATA === 16'hffff && RSP_STATUS.locked === 1'b0, "blank read");
    run(OP_PROGRAM, 18'h1, 16'h00a5, 1'b0);
    ck(!RSP_STATUS.failed && RSP_DATA === 16'h00a5 && wr_cnt == 4, "program");
    run(OP_PROGRAM, 18'h1, 16'h00ff, 1'b0);
    ck(RSP_STATUS.failed === 1'b1 && wr_cnt == 5, "one over zero");
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_DATA === 16'h00a5, "read after recovery");
  endtask : t_prog

  task automatic t_block;
    run(OP_BLOCK_ERASE, 18'h1, 16'h0, 1'b0);
    ck(RSP_STATUS.maybe_rejected === 1'b0 && wr_cnt == 6, "block erase");
    run(OP_BLOCK_ERASE, 18'h4, 16'h0, 1'b0);
    ck(!RSP_STATUS.window_closed && RSP_STATUS.maybe_rejected === 1'b0, "added");
    run(OP_ERASE_WAIT, 18'h1, 16'h0, 1'b0);
    ck(RSP_STATUS.failed === 1'b0 && RSP_DATA === 16'hffff, "erase done");
  endtask : t_block

  task automatic t_fail;
    fail_nx = 1'b1;
    run(OP_CHIP_ERASE, 18'h1, 16'h0, 1'b0);
    fail_nx = 1'b0;
    ck(RSP_STATUS.failed === 1'b1 && wr_cnt == 7, "erase time limit");
  endtask : t_fail

  task automatic t_lock;
    run(OP_PROGRAM, 18'h1, 16'h0012, 1'b0);
    run(OP_LOCK, 18'h0, 16'h0, 1'b1);
    ck(RSP_STATUS.failed === 1'b0 && wr_cnt == 4, "lock");
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_DATA === 16'h0098 && RSP_STATUS.locked === 1'b1, "locked read");
    run(OP_UNLOCK, 18'h1, 16'h0, 1'b1);
    ck(RSP_STATUS.failed === 1'b0 && wr_cnt == 6, "unlock");
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_DATA === 16'hffff && RSP_STATUS.locked === 1'b0, "wiped read");
  endtask : t_lock

  task automatic t_abort;
    int n;
    n = 0;
    @(negedge REF_CLK);
    fse_exp = 1'b1;
    CMD_VALID = 1'b1;
    CMD = '{OP_LOCK, 18'h0, 16'h0};
    while (FL_READY_BUSY_PIN !== 1'b0 && n < 200)
    begin
      @(negedge REF_CLK);
      n++;
    end
    CMD_VALID = 1'b0;
    RESET = 1'b1;
    repeat (4) @(negedge REF_CLK);
    RESET = 1'b0;
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_STATUS.locked === 1'b0 && n < 200, "reset abort");
  endtask : t_abort

  task automatic t_busy;
    hold = 1'b1;
    run(OP_PROGRAM, 18'h2, 16'h0011, 1'b0);
    hold = 1'b0;
    ck(RSP_STATUS.rdy_timeout === 1'b1 && wr_cnt == 0, "busy refusal");
  endtask : t_busy

  // a request made while frozen must not start any flash cycle
  task automatic t_freeze;
    @(negedge REF_CLK);
    CLK_EN = 1'b0;
    CMD_VALID = 1'b1;
    CMD = '{OP_READ, 18'h1, 16'h0};
    repeat (20) @(negedge REF_CLK);
    ck(FL_CE_N === 1'b1 && FL_OE_N === 1'b1 && RSP_VALID === 1'b0, "frozen");
    CMD_VALID = 1'b0;
    CLK_EN = 1'b1;
    run(OP_READ, 18'h1, 16'h0, 1'b0);
    ck(RSP_DATA === 16'hffff, "read after freeze");
  endtask : t_freeze

  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  // whole run is about a thousand cycles
  initial
  begin
    #500000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    RESET = 1'b1;
    CLK_EN = 1'b1;
    CMD_VALID = 1'b0;
    CMD = '0;
    fse_exp = 1'b0;
    fail_nx = 1'b0;
    hold = 1'b0;
    repeat (4) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RESET = 1'b0;
    t_prog();
    t_block();
    t_fail();
    t_lock();
    t_abort();
    t_busy();
    t_freeze();
    report_and_stop();
  end
endmodule : testbench
